// >>> hw/eplk_defs.svh
// Offsets, field positions, signature locations, erased value and timing counts of the EPROM access block.
// Assumes inclusion by the package and the top module only.
`ifndef EPLK_DEFS_SVH
`define EPLK_DEFS_SVH
// Register byte offsets
`define EPLK_REG_CTRL      4'h0
`define EPLK_REG_STATUS    4'h4
`define EPLK_REG_PULSES    4'h8
// Field positions
`define EPLK_CTRL_ERASE    0
`define EPLK_ST_ERASING    0
`define EPLK_ST_LOCK_LSB   1
`define EPLK_ST_REFUSED    4
`define EPLK_ST_EA_LATCHED 5
// Signature locations
`define EPLK_SIG_ADDR0     15'h0030
`define EPLK_SIG_ADDR1     15'h0031
`define EPLK_SIG_ADDR2     15'h0060
// Erased cell value
`define EPLK_ERASED_BYTE   8'hff
// Verify answer bound: 48 oscillator periods at the fastest 6 MHz oscillator
`define EPLK_VERIFY_PERIODS 48
`define EPLK_OSC_MAX_KHZ    6000
`define EPLK_CORE_PERIOD_NS 4
`define EPLK_VERIFY_MAX_CYC \
  ((`EPLK_VERIFY_PERIODS * 1000000 / `EPLK_OSC_MAX_KHZ) / `EPLK_CORE_PERIOD_NS)
// Cycles from pin change to data actually seen on the data lines
`define EPLK_VERIFY_LAT_CYC 2
`endif

// >>> hw/eplk_pkg.sv
// Types shared by the EPROM access block.
// Assumes the defs header is on the include path.
package eplk_pkg;
  `include "eplk_defs.svh"

  typedef enum logic [2:0] {
    EPLK_MODE_IDLE,
    EPLK_MODE_PROG_CODE,
    EPLK_MODE_VERIFY_CODE,
    EPLK_MODE_PROG_ENC,
    EPLK_MODE_PROG_LOCK1,
    EPLK_MODE_PROG_LOCK2,
    EPLK_MODE_PROG_LOCK3,
    EPLK_MODE_READ_SIG
  } eplk_mode_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic        strobe_prev;
    logic [2:0]  lock;
    logic        refused;
    logic        erasing;
    logic [14:0] erase_idx;
    logic [15:0] pulses;
    logic        ea_done;
    logic        ea_latched;
    logic [7:0]  dout;
    logic        doe;
  } eplk_state_t;
endpackage

// >>> hw/eplk_mode_dec.sv
// Decoder of the programming control lines into an access mode.
// Assumes all control lines are synchronous to the core clock.
module eplk_mode_dec
  import eplk_pkg::*;
(
  // Control lines
  input  wire logic       entry_i,
  input  wire logic [3:0] sel_i,
  input  wire logic       verify_enable_line_i,
  // Decoded mode
  output eplk_mode_t      mode_o
);
  // Select lines are {ctl_a, ctl_b, ctl_c, ctl_d}; enable line is the low bit of every code, ignored for verify and signature read
  always_comb begin
    mode_o = EPLK_MODE_IDLE;
    if (entry_i) begin
      unique case ({sel_i, verify_enable_line_i})
        5'h0f:   mode_o = EPLK_MODE_PROG_CODE;
        5'h0d:   mode_o = EPLK_MODE_PROG_ENC;
        5'h1f:   mode_o = EPLK_MODE_PROG_LOCK1;
        5'h19:   mode_o = EPLK_MODE_PROG_LOCK2;
        5'h1c:   mode_o = EPLK_MODE_PROG_LOCK3;
        5'h06,
        5'h07:   mode_o = EPLK_MODE_VERIFY_CODE;
        5'h00,
        5'h01:   mode_o = EPLK_MODE_READ_SIG;
        default: mode_o = EPLK_MODE_IDLE;
      endcase
    end
  end
endmodule

// >>> hw/eplk_top.sv
// The Avalon-MM register port and the register offsets are this design's own decisions.
`include "eplk_defs.svh"
// EPROM program, verify and lock logic with an Avalon-MM register slave.
// Assumes the programmer keeps its own setup, hold, pulse and supply timing.
module eplk_top
  import eplk_pkg::*;
#(
  parameter int         CODE_DEPTH = 4096,
  parameter int         ENC_DEPTH  = 64,
  parameter logic [7:0] SIG_BYTE0  = 8'ha5, // Arbitrary value
  parameter logic [7:0] SIG_BYTE1  = 8'h3c, // Arbitrary value
  parameter logic [7:0] SIG_BYTE2  = 8'h7e  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        CORE_CLK_I,
  input  wire logic        SYS_RST_I,
  // Avalon-MM slave
  input  wire logic [3:0]  ADDRESS_I,
  input  wire logic        READ_I,
  input  wire logic        WRITE_I,
  input  wire logic [31:0] WRITEDATA_I,
  output logic [31:0]      READDATA_O,
  output logic             WAITREQUEST_O,
  // Programmer pins
  input  wire logic        PROG_ENTRY_I,
  input  wire logic [14:0] PIN_ADDR_I,
  input  wire logic [7:0]  PIN_DATA_I,
  output logic [7:0]       PIN_DATA_O,
  output logic             PIN_DATA_OE_O,
  input  wire logic [3:0]  MODE_SEL_I,
  input  wire logic        VERIFY_ENABLE_LINE_I,
  input  wire logic        PROGRAM_STROBE_I,
  input  wire logic        EXTERNAL_ACCESS_PROGRAM_SUPPLY_I,
  input  wire logic        PROG_SUPPLY_ON_I,
  // Protection status
  output logic             TABLE_READ_BLOCK_O,
  output logic             EXT_EXEC_BLOCK_O,
  output logic             EA_EFFECTIVE_O
);
  localparam int AW = $clog2(CODE_DEPTH);
  localparam int EW = $clog2(ENC_DEPTH);

  // Table index uses six address bits; the array must fit the address pins
  initial begin
    if (CODE_DEPTH < ENC_DEPTH || CODE_DEPTH > 32768 || (1 << AW) != CODE_DEPTH)
      $error("CODE_DEPTH must be a power of two up to 32768");
    if (ENC_DEPTH != 64)
      $error("ENC_DEPTH must be 64");
  end

  // Register index from byte address, shared by read and write decode
  function automatic logic [1:0] reg_idx(input logic [3:0] a);
    reg_idx = a[3:2];
  endfunction

  // Signature byte lookup; other addresses read erased
  function automatic logic [7:0] sig_byte(input logic [14:0] a);
    if (a == `EPLK_SIG_ADDR0)
      sig_byte = SIG_BYTE0;
    else if (a == `EPLK_SIG_ADDR1)
      sig_byte = SIG_BYTE1;
    else if (a == `EPLK_SIG_ADDR2)
      sig_byte = SIG_BYTE2;
    else
      sig_byte = `EPLK_ERASED_BYTE;
  endfunction

  eplk_state_t s_q;
  eplk_state_t s_d;
  eplk_mode_t  mode;
  logic [7:0]  code_mem [CODE_DEPTH];
  logic [7:0]  enc_mem  [ENC_DEPTH];
  logic [7:0]  code_rd;
  logic [7:0]  enc_rd;
  logic        code_we;
  logic        enc_we;
  logic [AW-1:0] code_wa;
  logic [EW-1:0] enc_wa;
  logic [7:0]  code_wd;
  logic [7:0]  enc_wd;
  logic        req;
  logic        pulse;
  logic        vmode;

  eplk_mode_dec u_mode (
    .entry_i              (PROG_ENTRY_I),
    .sel_i                (MODE_SEL_I),
    .verify_enable_line_i (VERIFY_ENABLE_LINE_I),
    .mode_o               (mode)
  );

  // Cell arrays; no reset, contents are cleared only by the erase walk
  always_ff @(posedge CORE_CLK_I) begin
    if (code_we)
      code_mem[code_wa] <= code_wd;
    if (enc_we)
      enc_mem[enc_wa] <= enc_wd;
    code_rd <= code_mem[PIN_ADDR_I[AW-1:0]];
  end
  assign enc_rd = enc_mem[PIN_ADDR_I[EW-1:0]];

  assign req   = READ_I | WRITE_I;
  assign vmode = (mode == EPLK_MODE_VERIFY_CODE) || (mode == EPLK_MODE_READ_SIG);
  // Falling strobe with supply raised; ignored while erasing
  assign pulse = s_q.strobe_prev & ~PROGRAM_STROBE_I & PROG_SUPPLY_ON_I & ~s_q.erasing;

  // Next-state logic
  always_comb begin
    s_d         = s_q;
    code_we     = 1'b0;
    enc_we      = 1'b0;
    code_wa     = PIN_ADDR_I[AW-1:0];
    enc_wa      = PIN_ADDR_I[EW-1:0];
    // Cells only lose ones when programmed, so new value ANDs with old
    code_wd     = code_rd & PIN_DATA_I;
    enc_wd      = enc_rd & PIN_DATA_I;
    s_d.strobe_prev = PROGRAM_STROBE_I;

    if (!s_q.ea_done) begin
      s_d.ea_done    = 1'b1;
      s_d.ea_latched = EXTERNAL_ACCESS_PROGRAM_SUPPLY_I;
    end

    if (pulse) begin
      unique case (mode)
        EPLK_MODE_PROG_CODE,
        EPLK_MODE_PROG_ENC: begin
          if (s_q.lock[0]) begin
            s_d.refused = 1'b1;
          end else begin
            code_we    = (mode == EPLK_MODE_PROG_CODE);
            enc_we     = (mode == EPLK_MODE_PROG_ENC);
            s_d.pulses = s_q.pulses + 16'h0001;
          end
        end
        EPLK_MODE_PROG_LOCK1: s_d.lock[0] = 1'b1;
        EPLK_MODE_PROG_LOCK2: s_d.lock[1] = 1'b1;
        EPLK_MODE_PROG_LOCK3: s_d.lock[2] = 1'b1;
        EPLK_MODE_IDLE,
        EPLK_MODE_VERIFY_CODE,
        EPLK_MODE_READ_SIG: ;
      endcase
    end

    if (s_q.erasing) begin
      code_we       = 1'b1;
      code_wa       = s_q.erase_idx[AW-1:0];
      code_wd       = `EPLK_ERASED_BYTE;
      enc_we        = (s_q.erase_idx < 15'(ENC_DEPTH));
      enc_wa        = s_q.erase_idx[EW-1:0];
      enc_wd        = `EPLK_ERASED_BYTE;
      s_d.erase_idx = s_q.erase_idx + 15'h0001;
      if (s_q.erase_idx == 15'(CODE_DEPTH - 1))
        s_d.erasing = 1'b0;
    end

    // Drive data while enable is low
    s_d.doe = vmode & ~VERIFY_ENABLE_LINE_I & ~s_q.erasing;
    if (mode == EPLK_MODE_READ_SIG)
      s_d.dout = sig_byte(PIN_ADDR_I);
    else if (s_q.lock[0] && s_q.lock[1])
      s_d.dout = `EPLK_ERASED_BYTE;
    else
      s_d.dout = ~(code_rd ^ enc_rd);

    // Bus: one wait cycle, read data captured in it
    s_d.ack = req & ~s_q.ack;
    if (req && !s_q.ack && READ_I) begin
      unique case (reg_idx(ADDRESS_I))
        2'h0: s_d.rdata = 32'h0;
        2'h1: s_d.rdata = {26'h0, s_q.ea_latched, s_q.refused, s_q.lock, s_q.erasing};
        2'h2: s_d.rdata = {16'h0, s_q.pulses};
        2'h3: s_d.rdata = 32'h0;
      endcase
    end
    if (req && s_q.ack && WRITE_I) begin
      if (reg_idx(ADDRESS_I) == reg_idx(`EPLK_REG_CTRL) &&
          WRITEDATA_I[`EPLK_CTRL_ERASE] && !s_q.erasing) begin
        s_d.erasing   = 1'b1;
        s_d.erase_idx = 15'h0;
        s_d.lock      = 3'h0;
        s_d.refused   = 1'b0;
      end
      // Write-one clears; a refusal in the same cycle wins
      if (reg_idx(ADDRESS_I) == reg_idx(`EPLK_REG_STATUS) &&
          WRITEDATA_I[`EPLK_ST_REFUSED] && !(pulse && s_q.lock[0]))
        s_d.refused = 1'b0;
      if (reg_idx(ADDRESS_I) == reg_idx(`EPLK_REG_PULSES))
        s_d.pulses = 16'h0;
    end
  end

  // State register
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign READDATA_O    = s_q.rdata;
  assign WAITREQUEST_O = req & ~s_q.ack;
  assign PIN_DATA_O    = s_q.dout;
  assign PIN_DATA_OE_O = s_q.doe;
  // Table read block at lock one
  assign TABLE_READ_BLOCK_O = s_q.lock[0];
  // External execution off once all three lock bits are set
  assign EXT_EXEC_BLOCK_O   = &s_q.lock;
  // Latched copy only counts once lock one is set
  assign EA_EFFECTIVE_O = s_q.lock[0] ? s_q.ea_latched : EXTERNAL_ACCESS_PROGRAM_SUPPLY_I;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  AST_SIG_BYTE0: assert property (
    (mode == EPLK_MODE_READ_SIG && !VERIFY_ENABLE_LINE_I && !s_q.erasing &&
     PIN_ADDR_I == `EPLK_SIG_ADDR0)[*3] |-> PIN_DATA_OE_O && PIN_DATA_O == SIG_BYTE0)
    else $error("signature byte 0 wrong");
  AST_ERASE_END: assert property (
    s_q.erasing && s_q.erase_idx == 15'(CODE_DEPTH - 1) |=> !s_q.erasing && s_q.lock == 3'h0)
    else $error("erase did not finish clean");
  AST_ERASE_ONES: assert property (
    s_q.erasing |-> code_we && code_wd == 8'hff)
    else $error("erase wrote a zero");
  AST_VERIFY_XNOR: assert property (
    (mode == EPLK_MODE_VERIFY_CODE && !VERIFY_ENABLE_LINE_I && !s_q.erasing &&
     !(s_q.lock[0] && s_q.lock[1]) && $stable(PIN_ADDR_I) && !code_we && !enc_we)[*3]
    |-> PIN_DATA_O == ~($past(code_rd) ^ $past(enc_rd)))
    else $error("verify data not table XNOR code");
  AST_REFUSE: assert property (
    pulse && s_q.lock[0] && mode == EPLK_MODE_PROG_CODE |-> !code_we ##1 s_q.refused)
    else $error("locked programming not refused");
  AST_VERIFY_OFF: assert property (
    s_q.lock[0] && s_q.lock[1] && $past(mode) == EPLK_MODE_VERIFY_CODE && PIN_DATA_OE_O
    |-> PIN_DATA_O == 8'hff)
    else $error("verify leaked under lock");
  AST_EXT_EXEC: assert property (
    EXT_EXEC_BLOCK_O |-> TABLE_READ_BLOCK_O && s_q.lock == 3'h7)
    else $error("external execution block wrong");
  AST_DRIVE: assert property (
    (vmode && !VERIFY_ENABLE_LINE_I && !s_q.erasing)[*2] |-> PIN_DATA_OE_O)
    else $error("verify data not driven in time");
  AST_RELEASE: assert property (
    VERIFY_ENABLE_LINE_I |=> !PIN_DATA_OE_O)
    else $error("data lines not released");
  AST_BUS_WAIT: assert property (
    req && WAITREQUEST_O && $stable(ADDRESS_I) |=> !WAITREQUEST_O)
    else $error("bus answer late");
endmodule

// >>> tb/eplk_prog_model.sv
// Programmer model: drives address, data, mode lines and strobe pulses.
// Assumes one core cycle stands for one oscillator period, so counts are scaled.
module eplk_prog_model #(
  parameter int SETUP_CYC = 48,
  parameter int PW_CYC    = 4,
  parameter int GAP_CYC   = 3
) (
  input  wire logic        clk_i,
  input  wire logic [7:0]  dev_data_i,
  input  wire logic        dev_oe_i,
  output logic             entry_o,
  output logic [14:0]      addr_o,
  output logic [7:0]       data_o,
  output logic [3:0]       sel_o,
  output logic             en_o,
  output logic             strobe_o,
  output logic             ea_o,
  output logic             supply_o,
  output logic             got_o,
  output logic [8:0]       got_d_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pdat;
  logic       drv;
  // Released lines show the inverse, not a stale byte
  assign data_o = dev_oe_i ? dev_data_i : (drv ? pdat : ~pdat);
  initial begin
    {entry_o, en_o, strobe_o, ea_o} = 4'hf;
    {addr_o, pdat, drv, sel_o, supply_o, got_o, got_d_o} = '0;
  end
  task automatic burst(input logic [4:0] md, input logic [14:0] a, input logic [7:0] d,
                       input int n);
    @(posedge clk_i);
    addr_o <= a;
    pdat <= d;
    drv <= 1'b1;
    {sel_o, en_o} <= md;
    repeat (SETUP_CYC) @(posedge clk_i);
    supply_o <= 1'b1;
    repeat (GAP_CYC) @(posedge clk_i);
    repeat (n) begin
      strobe_o <= 1'b0;
      repeat (PW_CYC) @(posedge clk_i);
      strobe_o <= 1'b1;
      repeat (GAP_CYC) @(posedge clk_i);
    end
    supply_o <= 1'b0;
    repeat (SETUP_CYC) @(posedge clk_i);
    drv <= 1'b0;
    {sel_o, en_o} <= 5'h01;
  endtask
  // verify sequence, sample at bound then after release
  task automatic look(input logic [4:0] md, input logic [14:0] a);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      if (k == 0) begin
        addr_o <= a;
        {sel_o, en_o} <= md;
      end
      else en_o <= 1'b1;
      repeat (SETUP_CYC) @(posedge clk_i);
      got_o <= 1'b1;
      got_d_o <= {dev_oe_i, dev_data_i};
      @(posedge clk_i);
      got_o <= 1'b0;
    end
  endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench of the EPROM access block: Avalon master plus programmer model.
// Assumes a shortened erase through CODE_DEPTH = 64.
module testbench;
  import eplk_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] M_VER = 5'h06, M_SIG = 5'h00, M_PC = 5'h0f, M_PT = 5'h0d;
  localparam logic [4:0] M_L1 = 5'h1f, M_L2 = 5'h19, M_L3 = 5'h1c;
  logic CORE_CLK_I, SYS_RST_I, READ_I, WRITE_I, WAITREQUEST_O, PIN_DATA_OE_O, snap;
  logic [3:0] ADDRESS_I, MODE_SEL_I;
  logic [31:0] WRITEDATA_I, READDATA_O, r;
  logic [14:0] PIN_ADDR_I;
  logic [7:0] PIN_DATA_I, PIN_DATA_O, c, t;
  logic PROG_ENTRY_I, VERIFY_ENABLE_LINE_I, PROGRAM_STROBE_I, EA_I, SUP_I, got;
  logic TABLE_READ_BLOCK_O, EXT_EXEC_BLOCK_O, EA_EFFECTIVE_O;
  logic [8:0] got_d;
  logic [63:0] bq[$], pq[$], sq[$];
  int errors = 0, tests_run = 0;
  eplk_top #(.CODE_DEPTH(64)) eplk_top_inst (.CORE_CLK_I, .SYS_RST_I, .ADDRESS_I, .READ_I,
    .WRITE_I, .WRITEDATA_I, .READDATA_O, .WAITREQUEST_O, .PROG_ENTRY_I, .PIN_ADDR_I,
    .PIN_DATA_I, .PIN_DATA_O, .PIN_DATA_OE_O, .MODE_SEL_I, .VERIFY_ENABLE_LINE_I,
    .PROGRAM_STROBE_I, .EXTERNAL_ACCESS_PROGRAM_SUPPLY_I(EA_I), .PROG_SUPPLY_ON_I(SUP_I),
    .TABLE_READ_BLOCK_O, .EXT_EXEC_BLOCK_O, .EA_EFFECTIVE_O);
  eplk_prog_model eplk_prog_model_inst (.clk_i(CORE_CLK_I), .dev_data_i(PIN_DATA_O),
    .dev_oe_i(PIN_DATA_OE_O), .entry_o(PROG_ENTRY_I), .addr_o(PIN_ADDR_I),
    .data_o(PIN_DATA_I), .sel_o(MODE_SEL_I), .en_o(VERIFY_ENABLE_LINE_I),
    .strobe_o(PROGRAM_STROBE_I), .ea_o(EA_I), .supply_o(SUP_I), .got_o(got), .got_d_o(got_d));
  // Free-running 250 MHz clock
  always #2 CORE_CLK_I = ~CORE_CLK_I;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic cmp(input logic [31:0] g, input logic [63:0] e);
    tests_run++;
    if (((g ^ e[31:0]) & e[63:32]) !== 32'h0) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e[31:0]);
    end
  endtask
  task automatic give_verdict();
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Avalon master: hold until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    @(posedge CORE_CLK_I);
    {WRITE_I, READ_I, ADDRESS_I, WRITEDATA_I} <= {w, !w, a, d};
    if (!w) bq.push_back({m, d});
    do @(posedge CORE_CLK_I); while (WAITREQUEST_O !== 1'b0);
    r = READDATA_O;
    {WRITE_I, READ_I} <= 2'b00;
  endtask
  task automatic vfy(input logic [4:0] md, input logic [14:0] a, input logic [7:0] e);
    pq.push_back({32'h1ff, 24'h1, e});
    pq.push_back({32'h100, 32'h0});
    eplk_prog_model_inst.look(md, a);
  endtask
  task automatic sts(input logic [2:0] e);
    sq.push_back({32'h7, 29'h0, e});
    @(posedge CORE_CLK_I);
    snap <= 1'b1;
    @(posedge CORE_CLK_I);
    snap <= 1'b0;
  endtask
  task automatic erase();
    bus(1, 4'h0, 32'h1, 0);
    do bus(0, 4'h4, 0, 0); while (r[0] !== 1'b0);
  endtask
  // Result watcher: oldest note per kind against each result
  always @(posedge CORE_CLK_I) begin
    if (READ_I && !WAITREQUEST_O) cmp(READDATA_O, bq.pop_front());
    if (got) cmp({23'h0, got_d}, pq.pop_front());
    if (snap) cmp({TABLE_READ_BLOCK_O, EXT_EXEC_BLOCK_O, EA_EFFECTIVE_O}, sq.pop_front());
  end
  // Watchdog
  initial begin
    repeat (40000) @(posedge CORE_CLK_I);
    errors++;
    give_verdict();
  end
  // Main sequence
  initial begin
    {CORE_CLK_I, READ_I, WRITE_I, ADDRESS_I, WRITEDATA_I, snap} = '0;
    SYS_RST_I = 1'b1;
    repeat (3) @(posedge CORE_CLK_I);
    SYS_RST_I <= 1'b0;
    c = lfsr(8'h5b); // Seed 91
    t = lfsr(c);
    sts(3'b001);
    erase();
    bus(0, 4'h4, 0, 32'h1f);
    vfy(M_VER, 15'h0006, 8'hff);
    eplk_prog_model_inst.burst(M_PC, 15'h0005, c, 5);
    vfy(M_VER, 15'h0005, c);
    eplk_prog_model_inst.burst(M_PT, 15'h0005, t, 25);
    vfy(M_VER, 15'h0005, ~(c ^ t));
    vfy(M_SIG, 15'h0030, 8'ha5);
    vfy(M_SIG, 15'h0031, 8'h3c);
    vfy(M_SIG, 15'h0060, 8'h7e);
    vfy(M_SIG, 15'h0010, 8'hff);
    bus(0, 4'h8, 32'h1e, 32'hffff);
    bus(0, 4'hc, 0, 32'hffffffff);
    eplk_prog_model_inst.ea_o <= 1'b0;
    sts(3'b000);
    eplk_prog_model_inst.burst(M_L1, 15'h0, 8'h0, 25);
    sts(3'b101);
    eplk_prog_model_inst.burst(M_PC, 15'h0005, 8'h00, 5);
    bus(0, 4'h4, 32'h12, 32'h1f);
    bus(0, 4'h8, 32'h1e, 32'hffff);
    vfy(M_VER, 15'h0005, ~(c ^ t));
    bus(1, 4'h4, 32'h10, 0);
    bus(0, 4'h4, 32'h02, 32'h1f);
    eplk_prog_model_inst.burst(M_L2, 15'h0, 8'h0, 25);
    vfy(M_VER, 15'h0005, 8'hff);
    eplk_prog_model_inst.burst(M_L3, 15'h0, 8'h0, 25);
    sts(3'b111);
    bus(0, 4'h4, 32'h0e, 32'h1f);
    erase();
    bus(0, 4'h4, 0, 32'h1f);
    sts(3'b000);
    vfy(M_VER, 15'h0005, 8'hff);
    give_verdict();
  end
endmodule
